// ---- core/pllc_top.sv ----
// Operation
// - Reset comes up bypassed until select set
// - Multiplier resets to 13, range 4 to 25
// - System clock one defaults to VCO over one
// - System clock two defaults to VCO over two
// - System clock three defaults to VCO over three
// - Post divider changes apply on go command
// - Both clock inputs combined before the PLL
// - Four output clocks, each behind a divider
`timescale 1ns/1ps
`include "pllc_map.svh"

module pllc_top #(
  parameter int          LOCK_CYCLES = int'(`PLLC_LOCK_MIN_CYC),
  parameter logic [31:0] IDENT_VALUE = 32'h00A5015A  // Arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        oscillator_input_pin,
  input  wire logic        external_clock_pin,
  output logic             prediv_reference_tick,
  output logic             system_clock_one_tick,
  output logic             system_clock_two_tick,
  output logic             system_clock_three_tick,
  output logic             pll_locked,
  output logic             bypass_active
);

  localparam int RESET_CYCLES = int'(`PLLC_RESET_MIN_CYC);

  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_chk_lock
    $error("pllc_top: LOCK_CYCLES must be 1 to 65535");
  end
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_chk_rst
    $error("pllc_top: reset hold count out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register state

  logic                       pll_select_enable_reg;
  logic                       pll_reset_bit_reg;
  logic                       reset_short_reg;
  pllc_pkg::pllc_ratio_type   multiplier_setting_reg;
  pllc_pkg::pllc_ratio_type   pre_divider_reg;
  pllc_pkg::pllc_ratio_type   pend_ratio_reg [1:3];
  pllc_pkg::pllc_ratio_type   act_ratio_reg [1:3];
  logic [2:0]                 align_control_reg;
  logic [3:0]                 clock_enable_reg;
  logic                       go_busy_reg;
  logic [31:0]                rdata_next;

  pllc_pkg::pllc_lock_state_type lock_state_reg;
  logic [15:0]                lock_cnt_reg;
  logic [7:0]                 hold_cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_csr;
  logic wr_mult;
  logic wr_div0;
  logic wr_cmd;
  logic wr_align;
  logic wr_clock_enable_control;
  logic go_write;
  logic go_apply;
  logic relock;
  logic mult_out_of_range;

  assign wr_csr   = reg_wr && (reg_addr == `PLLC_ADDR_CSR);
  assign wr_mult  = reg_wr && (reg_addr == `PLLC_ADDR_MULT);
  assign wr_div0  = reg_wr && (reg_addr == `PLLC_ADDR_DIV0);
  assign wr_cmd   = reg_wr && (reg_addr == `PLLC_ADDR_CMD);
  assign wr_align = reg_wr && (reg_addr == `PLLC_ADDR_ALIGN);
  assign wr_clock_enable_control  = reg_wr && (reg_addr == `PLLC_ADDR_CLOCK_ENABLE_CONTROL);
  assign go_write = wr_cmd && reg_wdata[`PLLC_CMD_GO_BIT];

  // Input clock changes and new loop settings force a fresh lock wait
  assign relock = wr_mult || wr_div0;

  assign mult_out_of_range = (multiplier_setting_reg < `PLLC_MULT_MIN) ||
                             (multiplier_setting_reg > `PLLC_MULT_MAX);

  //////////////////////////////////////////////////////////////////////////////
  // Reference input

  logic [1:0] pins_sync;
  logic       ref_level;
  logic       ref_level_d_reg;
  logic       ref_tick;

  pllc_sync #(
    .WIDTH    (2)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({external_clock_pin, oscillator_input_pin}),
    .sync_out (pins_sync)
  );

  // Unused input must sit low, otherwise it corrupts the reference
  assign ref_level = pins_sync[0] | pins_sync[1];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_level_d_reg <= 1'b0;
    end else begin
      ref_level_d_reg <= ref_level;
    end
  end

  assign ref_tick = ref_level & ~ref_level_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Control and status register

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pll_select_enable_reg <= `PLLC_RST_SEL;
      pll_reset_bit_reg     <= `PLLC_RST_PLL_RESET_BIT;
    end else if (wr_csr) begin
      pll_select_enable_reg <= reg_wdata[`PLLC_CSR_SEL_BIT];
      pll_reset_bit_reg     <= reg_wdata[`PLLC_CSR_RST_BIT];
    end
  end

  // Reset hold timer; a short hold is flagged rather than trusted
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_reg <= 8'h00;
    end else if (!pll_reset_bit_reg) begin
      hold_cnt_reg <= 8'h00;
    end else if (hold_cnt_reg < 8'(RESET_CYCLES)) begin
      hold_cnt_reg <= hold_cnt_reg + 8'h01;
    end
  end

  logic reset_release;
  assign reset_release = pll_reset_bit_reg && wr_csr && !reg_wdata[`PLLC_CSR_RST_BIT];

  // Set wins over the write-one clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_short_reg <= 1'b0;
    end else if (reset_release && (hold_cnt_reg < 8'(RESET_CYCLES))) begin
      reset_short_reg <= 1'b1;
    end else if (wr_csr && reg_wdata[`PLLC_CSR_SHORT_BIT]) begin
      reset_short_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock tracking

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_state_reg <= pllc_pkg::PLLC_HELD;
      lock_cnt_reg   <= 16'h0000;
    end else if (pll_reset_bit_reg) begin
      lock_state_reg <= pllc_pkg::PLLC_HELD;
      lock_cnt_reg   <= 16'h0000;
    end else begin
      case (lock_state_reg)
        pllc_pkg::PLLC_HELD: begin
          lock_state_reg <= pllc_pkg::PLLC_LOCKING;
          lock_cnt_reg   <= 16'h0000;
        end
        pllc_pkg::PLLC_LOCKING: begin
          if (relock) begin
            lock_cnt_reg <= 16'h0000;
          end else if (lock_cnt_reg == 16'(LOCK_CYCLES - 1)) begin
            lock_state_reg <= pllc_pkg::PLLC_LOCKED;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
          end
        end
        pllc_pkg::PLLC_LOCKED: begin
          if (relock) begin
            lock_state_reg <= pllc_pkg::PLLC_LOCKING;
            lock_cnt_reg   <= 16'h0000;
          end
        end
        default: begin
          lock_state_reg <= pllc_pkg::PLLC_HELD;
        end
      endcase
    end
  end

  assign pll_locked = (lock_state_reg == pllc_pkg::PLLC_LOCKED);

  //////////////////////////////////////////////////////////////////////////////
  // Loop settings and dividers

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      multiplier_setting_reg <= `PLLC_RST_MULT;
    end else if (wr_mult) begin
      multiplier_setting_reg <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_divider_reg <= `PLLC_RST_DIV0;
    end else if (wr_div0) begin
      pre_divider_reg <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      align_control_reg <= `PLLC_RST_ALIGN;
      clock_enable_reg  <= `PLLC_RST_CLOCK_ENABLE_CONTROL;
    end else begin
      if (wr_align) begin
        align_control_reg <= reg_wdata[2:0];
      end
      if (wr_clock_enable_control) begin
        clock_enable_reg <= reg_wdata[3:0];
      end
    end
  end

  // VCO is modelled at the controller rate once locked
  logic vco_tick;
  logic src_tick;
  logic src_running;

  assign vco_tick      = pll_locked;
  assign bypass_active = ~pll_select_enable_reg;
  assign src_tick      = pll_select_enable_reg ? vco_tick : ref_tick;
  assign src_running   = pll_select_enable_reg ? pll_locked : 1'b1;

  // Post dividers take new ratios only on go, at a source edge
  assign go_apply = go_busy_reg && src_tick;

  // A new go in the apply cycle keeps busy set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      go_busy_reg <= 1'b0;
    end else if (go_write) begin
      go_busy_reg <= 1'b1;
    end else if (go_apply) begin
      go_busy_reg <= 1'b0;
    end
  end

  pllc_pkg::pllc_ratio_type div_ratio [0:3];
  logic [3:0]               div_tick_in;
  logic [3:0]               div_restart;
  logic [3:0]               div_tick_out;

  assign div_ratio[0]   = pre_divider_reg;
  assign div_tick_in[0] = ref_tick;
  assign div_restart[0] = wr_div0;

  for (genvar i = 1; i <= 3; i++) begin : g_post
    localparam logic [31:0] ADDR = `PLLC_ADDR_DIV1 + 32'(4 * (i - 1));
    localparam pllc_pkg::pllc_ratio_type RST =
      (i == 1) ? `PLLC_RST_DIV1 : (i == 2) ? `PLLC_RST_DIV2 : `PLLC_RST_DIV3;

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        pend_ratio_reg[i] <= RST;
      end else if (reg_wr && (reg_addr == ADDR)) begin
        pend_ratio_reg[i] <= reg_wdata[4:0];
      end
    end

    // Defaults give VCO over one, two and three
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        act_ratio_reg[i] <= RST;
      end else if (go_apply) begin
        act_ratio_reg[i] <= pend_ratio_reg[i];
      end
    end

    assign div_ratio[i]   = act_ratio_reg[i];
    assign div_tick_in[i] = src_tick;
    // Aligned dividers restart together so their edges coincide
    assign div_restart[i] = go_apply && align_control_reg[i-1];
  end

  for (genvar i = 0; i <= 3; i++) begin : g_div
    pllc_divider #(
      .WIDTH    (5)
    ) u_div (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .tick_in  (div_tick_in[i]),
      .restart  (div_restart[i]),
      .gate_en  (clock_enable_reg[i]),
      .ratio    (div_ratio[i]),
      .tick_out (div_tick_out[i])
    );
  end

  assign prediv_reference_tick   = div_tick_out[0];
  assign system_clock_one_tick   = div_tick_out[1];
  assign system_clock_two_tick   = div_tick_out[2];
  assign system_clock_three_tick = div_tick_out[3];

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `PLLC_ADDR_IDENT: rdata_next = IDENT_VALUE;
        `PLLC_ADDR_CSR: begin
          rdata_next[`PLLC_CSR_SEL_BIT]   = pll_select_enable_reg;
          rdata_next[`PLLC_CSR_SHORT_BIT] = reset_short_reg;
          rdata_next[`PLLC_CSR_RST_BIT]   = pll_reset_bit_reg;
          rdata_next[`PLLC_CSR_LOCK_BIT]  = pll_locked;
          rdata_next[`PLLC_CSR_RANGE_BIT] = mult_out_of_range;
        end
        `PLLC_ADDR_MULT:   rdata_next[4:0] = multiplier_setting_reg;
        `PLLC_ADDR_DIV0:   rdata_next[4:0] = pre_divider_reg;
        `PLLC_ADDR_DIV1:   rdata_next[4:0] = pend_ratio_reg[1];
        `PLLC_ADDR_DIV2:   rdata_next[4:0] = pend_ratio_reg[2];
        `PLLC_ADDR_DIV3:   rdata_next[4:0] = pend_ratio_reg[3];
        `PLLC_ADDR_STAT:   rdata_next[`PLLC_STAT_BUSY_BIT] = go_busy_reg;
        `PLLC_ADDR_ALIGN:  rdata_next[2:0] = align_control_reg;
        `PLLC_ADDR_CLOCK_ENABLE_CONTROL:   rdata_next[3:0] = clock_enable_reg;
        `PLLC_ADDR_CLOCK_STATUS: rdata_next[3:0] = clock_enable_reg & {4{src_running}};
        `PLLC_ADDR_SYSTEM_CLOCK_STATUS: rdata_next[2:0] = clock_enable_reg[3:1] & {3{src_running}};
        default:           rdata_next = 32'h00000000;
      endcase
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule : pllc_top

// ---- core/pllc_map.svh ----
`ifndef PLLC_MAP_SVH
`define PLLC_MAP_SVH

// Register byte addresses
`define PLLC_ADDR_IDENT     32'h41000000
`define PLLC_ADDR_CSR       32'h41000100
`define PLLC_ADDR_MULT      32'h41000110
`define PLLC_ADDR_DIV0      32'h41000114
`define PLLC_ADDR_DIV1      32'h41000118
`define PLLC_ADDR_DIV2      32'h4100011C
`define PLLC_ADDR_DIV3      32'h41000120
`define PLLC_ADDR_CMD       32'h41000138
`define PLLC_ADDR_STAT      32'h4100013C
`define PLLC_ADDR_ALIGN     32'h41000140
`define PLLC_ADDR_CLOCK_ENABLE_CONTROL      32'h41000148
`define PLLC_ADDR_CLOCK_STATUS    32'h4100014C
`define PLLC_ADDR_SYSTEM_CLOCK_STATUS    32'h41000150

// Control and status field positions
`define PLLC_CSR_SEL_BIT    0
`define PLLC_CSR_SHORT_BIT  1
`define PLLC_CSR_RST_BIT    3
`define PLLC_CSR_LOCK_BIT   6
`define PLLC_CSR_RANGE_BIT  7
`define PLLC_CMD_GO_BIT     0
`define PLLC_STAT_BUSY_BIT  0

// Reset values
`define PLLC_RST_SEL        1'h0
`define PLLC_RST_PLL_RESET_BIT     1'h1
`define PLLC_RST_MULT       5'h0D
`define PLLC_RST_DIV0       5'h00
`define PLLC_RST_DIV1       5'h00
`define PLLC_RST_DIV2       5'h01
`define PLLC_RST_DIV3       5'h02
`define PLLC_RST_ALIGN      3'h0
`define PLLC_RST_CLOCK_ENABLE_CONTROL       4'hF

// Multiplier range
`define PLLC_MULT_MIN       5'h04
`define PLLC_MULT_MAX       5'h19

// Timing
`define PLLC_CLK_HZ         64'd40000000
`define PLLC_RESET_MIN_NS   64'd125
`define PLLC_RESET_MIN_CYC  ((`PLLC_RESET_MIN_NS * `PLLC_CLK_HZ + 64'd999999999) / 64'd1000000000)
`define PLLC_LOCK_MIN_US    187.5
`define PLLC_LOCK_MIN_CYC   ($ceil(`PLLC_LOCK_MIN_US * 40.0))

`endif

// ---- core/pllc_pkg.sv ----
package pllc_pkg;

  typedef logic [4:0] pllc_ratio_type;

  typedef enum logic [1:0] {
    PLLC_HELD,
    PLLC_LOCKING,
    PLLC_LOCKED
  } pllc_lock_state_type;

endpackage : pllc_pkg

// ---- core/pllc_sync.sv ----
`timescale 1ns/1ps

module pllc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("pllc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pllc_sync

// ---- core/pllc_divider.sv ----
`timescale 1ns/1ps

module pllc_divider #(
  parameter int WIDTH = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             tick_in,
  input  wire logic             restart,
  input  wire logic             gate_en,
  input  wire logic [WIDTH-1:0] ratio,
  output logic                  tick_out
);

  logic [WIDTH-1:0] count_reg;
  logic             wrap;

  if (WIDTH < 1 || WIDTH > 16) begin : g_chk
    $error("pllc_divider: WIDTH must be 1 to 16");
  end

  assign wrap = (count_reg == ratio);

  // Ratio field holds divide value minus one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (restart) begin
      count_reg <= '0;
    end else if (tick_in) begin
      count_reg <= wrap ? '0 : count_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & wrap & gate_en & ~restart;
    end
  end

endmodule : pllc_divider

// ---- testbench/pllc_monitor.sv ----
`timescale 1ns/1ps
`include "pllc_map.svh"

module pllc_monitor (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        oscillator_input_pin,
  input wire logic        external_clock_pin,
  input wire logic        prediv_reference_tick,
  input wire logic        system_clock_one_tick,
  input wire logic        system_clock_two_tick,
  input wire logic        system_clock_three_tick,
  input wire logic        pll_locked,
  input wire logic        bypass_active
);
  logic [3:0] gate_reg;
  logic [3:0] idle_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the gate register, seen only through bus writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg <= 4'hF;
    end else if (reg_wr && reg_addr == `PLLC_ADDR_CLOCK_ENABLE_CONTROL) begin
      gate_reg <= reg_wdata[3:0];
    end
  end

  // Cycles since either reference pin was last high, while bypassed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idle_reg <= 4'h0;
    end else if (oscillator_input_pin || external_clock_pin || !bypass_active) begin
      idle_reg <= 4'h0;
    end else if (idle_reg != 4'hF) begin
      idle_reg <= idle_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence csr_wr_s;
    reg_wr && reg_addr == `PLLC_ADDR_CSR;
  endsequence

  select_follow_a : assert property (csr_wr_s |=> bypass_active == !$past(reg_wdata[0]))
    else $error("bypass does not follow the select write");
  bypass_hold_a : assert property (!(reg_wr && reg_addr == `PLLC_ADDR_CSR) |=> $stable(bypass_active))
    else $error("bypass changed without a control write");
  rdata_idle_a : assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  ref_quiet_a : assert property (idle_reg > 4'h8 |-> !(prediv_reference_tick || system_clock_one_tick || system_clock_two_tick || system_clock_three_tick))
    else $error("tick in bypass without a reference edge");
  lock_drop_a : assert property ($fell(pll_locked) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("lock lost without a register write");
  gate_prediv_a : assert property (!gate_reg[0] && !$past(gate_reg[0], 2) |-> !prediv_reference_tick)
    else $error("gated reference tick seen");
  gate_one_a : assert property (!gate_reg[1] && !$past(gate_reg[1], 2) |-> !system_clock_one_tick)
    else $error("gated system clock one tick seen");
  gate_two_a : assert property (!gate_reg[2] && !$past(gate_reg[2], 2) |-> !system_clock_two_tick)
    else $error("gated system clock two tick seen");
  gate_three_a : assert property (!gate_reg[3] && !$past(gate_reg[3], 2) |-> !system_clock_three_tick)
    else $error("gated system clock three tick seen");
endmodule : pllc_monitor

bind pllc_top pllc_monitor u_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .oscillator_input_pin(oscillator_input_pin), .external_clock_pin(external_clock_pin),
  .prediv_reference_tick(prediv_reference_tick), .system_clock_one_tick(system_clock_one_tick),
  .system_clock_two_tick(system_clock_two_tick),
  .system_clock_three_tick(system_clock_three_tick),
  .pll_locked(pll_locked), .bypass_active(bypass_active)
);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "pllc_map.svh"

module testbench;
  localparam int LOCK = 20;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        osc_pin = 1'b0;
  logic        ext_pin = 1'b0;
  logic [3:0]  tick;
  logic        pll_locked;
  logic        bypass_active;
  int          fails = 0;
  int          n_checks = 0;
  int          cnt [4] = '{4{0}};
  int          i;
  logic [4:0]  mv [4] = '{5'h03, 5'h04, 5'h19, 5'h1A};

  always #12.5 ref_clk = ~ref_clk;

  pllc_top #(.LOCK_CYCLES(LOCK), .IDENT_VALUE(32'h0000C0DE)) u_dut ( // Ident value arbitrary
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .oscillator_input_pin(osc_pin), .external_clock_pin(ext_pin),
    .prediv_reference_tick(tick[0]), .system_clock_one_tick(tick[1]),
    .system_clock_two_tick(tick[2]), .system_clock_three_tick(tick[3]),
    .pll_locked(pll_locked), .bypass_active(bypass_active)
  );

  always @(posedge ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (tick[k] === 1'b1) cnt[k]++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One idle cycle after each access so strobes never change twice in a step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(what, reg_rdata, exp);
    @(posedge ref_clk);
  endtask : rd

  task automatic pulse(input int n, input bit use_ext);
    repeat (n) begin
      if (use_ext) ext_pin <= 1'b1;
      else osc_pin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ext_pin <= 1'b0;
      osc_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
  endtask : pulse

  task automatic tally(input int e0, input int e1, input int e2, input int e3);
    @(negedge ref_clk);
    check("reference ticks", cnt[0], e0);
    check("clock one ticks", cnt[1], e1);
    check("clock two ticks", cnt[2], e2);
    check("clock three ticks", cnt[3], e3);
    cnt = '{4{0}};
    @(posedge ref_clk);
  endtask : tally

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check("bypass", bypass_active, 1'b1);
    rd("control", `PLLC_ADDR_CSR, 32'h8);
    rd("multiplier", `PLLC_ADDR_MULT, 32'hD);
    rd("divider zero", `PLLC_ADDR_DIV0, 32'h0);
    rd("divider one", `PLLC_ADDR_DIV1, 32'h0);
    rd("divider two", `PLLC_ADDR_DIV2, 32'h1);
    rd("divider three", `PLLC_ADDR_DIV3, 32'h2);
    rd("enables", `PLLC_ADDR_CLOCK_ENABLE_CONTROL, 32'hF);
    rd("unmapped", 32'h41000104, 32'h0);
    wr(`PLLC_ADDR_IDENT, 32'hFFFFFFFF);
    rd("ident", `PLLC_ADDR_IDENT, 32'h0000C0DE);
    for (i = 0; i < 4; i++) begin
      wr(`PLLC_ADDR_MULT, {27'h0, mv[i]});
      rd("range flag", `PLLC_ADDR_CSR, (i == 0 || i == 3) ? 32'h88 : 32'h8);
    end
    wr(`PLLC_ADDR_MULT, 32'hD);
    // Bypass: post dividers run straight off reference edges
    pulse(8, 1'b0);
    tally(8, 8, 4, 2);
    pulse(8, 1'b1);
    tally(8, 8, 4, 3);
    wr(`PLLC_ADDR_ALIGN, 32'h7);
    // Bridge two lies outside this block; its reset is left to the system
    wr(`PLLC_ADDR_DIV2, 32'h3);
    pulse(4, 1'b0);
    tally(4, 4, 2, 1);
    wr(`PLLC_ADDR_CMD, 32'h1);
    rd("go busy", `PLLC_ADDR_STAT, 32'h1);
    rd("command", `PLLC_ADDR_CMD, 32'h0);
    pulse(12, 1'b0);
    tally(12, 11, 2, 3);
    rd("go done", `PLLC_ADDR_STAT, 32'h0);
    // Release the PLL and wait out the lock count
    wr(`PLLC_ADDR_CSR, 32'h0);
    i = 0;
    while (pll_locked !== 1'b1 && i < 100) begin
      @(posedge ref_clk);
      i++;
    end
    if (i == 100) begin
      fails++;
      tally_and_finish();
    end
    check("lock time", 32'(i >= LOCK), 32'h1);
    rd("locked", `PLLC_ADDR_CSR, 32'h40);
    check("still bypass", bypass_active, 1'b1);
    wr(`PLLC_ADDR_CSR, 32'h1);
    check("selected", bypass_active, 1'b0);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    cnt = '{4{0}};
    repeat (24) @(posedge ref_clk);
    tally(0, 24, 6, 8);
    wr(`PLLC_ADDR_CLOCK_ENABLE_CONTROL, 32'h5);
    @(negedge ref_clk);
    cnt = '{4{0}};
    repeat (24) @(posedge ref_clk);
    tally(0, 0, 6, 0);
    rd("clock status", `PLLC_ADDR_CLOCK_STATUS, 32'h5);
    rd("system status", `PLLC_ADDR_SYSTEM_CLOCK_STATUS, 32'h2);
    wr(`PLLC_ADDR_MULT, 32'hD);
    check("lock dropped", pll_locked, 1'b0);
    rd("stopped status", `PLLC_ADDR_CLOCK_STATUS, 32'h0);
    // Release two cycles after asserting reset: too short a hold
    wr(`PLLC_ADDR_CSR, 32'h8);
    wr(`PLLC_ADDR_CSR, 32'h0);
    rd("short hold", `PLLC_ADDR_CSR, 32'h2);
    wr(`PLLC_ADDR_CSR, 32'h2);
    rd("short cleared", `PLLC_ADDR_CSR, 32'h0);
    // Pre divider halves reference edges; outputs one and three stay gated
    @(negedge ref_clk);
    cnt = '{4{0}};
    @(posedge ref_clk);
    wr(`PLLC_ADDR_DIV0, 32'h1);
    rd("divider zero set", `PLLC_ADDR_DIV0, 32'h1);
    pulse(4, 1'b0);
    tally(2, 0, 1, 0);
    tally_and_finish();
  end
endmodule : testbench
